// ==== asc_core.sv ====
`timescale 1ns/10ps
// What this block does
// - frames 8 or 9 data bits, ninth from tx_ninth_bit, LSB first.
// - enabling transmitter sends idle frame first; re-enable drops held data.
// - tx-empty and tx-done clear by status access then data write.
// - data write during a frame goes to the holding buffer.
// - data write when idle starts frame at once, tx-empty set again.
// - frame end (data or break) sets tx-done, interrupts if enabled.
// - tx-empty interrupts when its enable is set and mask clear.
// - break_send sends zero frames, then one mark bit when cleared.
// - rx_enable starts start-bit hunt; ninth received bit to rx_ninth_bit.
// - completed character moves to holding buffer, sets rx-full, interrupt.
// - rx-full clears by status access then data read.
// - character while rx-full sets overrun, buffer kept, interrupts.
// - noise sets noise flag with rx-full, data delivered, no own interrupt.
// - bad stop bit or break sets framing flag with rx-full.
// - idle frame on the line sets idle flag, interrupts if enabled.
// - rate is clock over 16, prescale 1/3/4/13, power of two.
// - nonzero fine prescaler divides that direction further, zero bypasses.
// - while muted no receive flags are set and rx interrupts blocked.
// - idle wake-up clears rx_mute without setting idle flag.
// - address wake-up clears rx_mute on msb one, delivers the word.
// - start bit low, stop bit high, line high when enabled idle.
module asc_core
(
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic [asc_pkg::ADDR_W-1:0]  adr_i,
	input  wire logic [31:0]                 dat_i,
	output logic      [31:0]                 dat_o,
	input  wire logic                        we_i,
	input  wire logic [3:0]                  sel_i,
	input  wire logic                        cyc_i,
	input  wire logic                        stb_i,
	output logic                             ack_o,
	input  wire logic                        irq_mask_i,
	output logic                             irq_o,
	input  wire logic                        rx_line_i,
	output logic                             tx_line_o,
	output logic                             tx_line_oe_o
);

	////////////////////////////////////////////////////////////////////////
	// registers
	asc_pkg::asc_status_s   st;
	asc_pkg::asc_ctrl2_s    c2;
	asc_pkg::asc_baud_s     baud;
	logic [7:0]             tx_fine_prescaler;
	logic [7:0]             rx_fine_prescaler;
	logic                   tx_ninth_bit;
	logic                   rx_ninth_bit;
	logic                   word9;
	logic                   wake_sel;
	logic [7:0]             rx_holding_buffer;
	logic [7:0]             tx_holding_buffer;
	logic                   hold_full;
	logic                   status_seen;

	////////////////////////////////////////////////////////////////////////
	// bus decode, effects land on the edge that samples ack
	wire acc       = cyc_i & stb_i & ack_o;
	wire req       = cyc_i & stb_i & ~ack_o;
	wire wr        = acc & we_i & sel_i[0];
	wire rd        = acc & ~we_i;
	wire hit_stat  = adr_i == asc_pkg::OFF_STATUS;
	wire hit_data  = adr_i == asc_pkg::OFF_DATA;
	wire data_wr   = wr & hit_data;
	wire data_rd   = rd & hit_data;
	wire ctrl2_wr  = wr & (adr_i == asc_pkg::OFF_CTRL2);
	// clear needs a prior status access
	wire tx_clr    = data_wr & status_seen;
	// clear needs a prior status access
	wire rx_clr    = data_rd & status_seen;
	wire [7:0] ctrl1_rd = {rx_ninth_bit, tx_ninth_bit, 1'b0, word9,
		wake_sel, 3'b000};
	wire [7:0] rd_byte =
		hit_stat ? st :
		hit_data ? rx_holding_buffer :
		(adr_i == asc_pkg::OFF_CTRL1)   ? ctrl1_rd :
		(adr_i == asc_pkg::OFF_CTRL2)   ? c2 :
		(adr_i == asc_pkg::OFF_BAUD)    ? baud :
		(adr_i == asc_pkg::OFF_TX_FINE) ? tx_fine_prescaler :
		(adr_i == asc_pkg::OFF_RX_FINE) ? rx_fine_prescaler : 8'h00;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= req;
			dat_o <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status_seen <= 1'b0;
		else if (rd & hit_stat)
			status_seen <= 1'b1;
		else if (data_wr | data_rd)
			status_seen <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// baud generation: shared prescale, then per-direction divider
	logic [3:0]  pr_cnt;
	logic [1:0]  samp_tick;
	wire  [3:0]  pr_div = asc_pkg::asc_prescale(baud.common_prescale_sel);
	wire         pr_tick = pr_cnt == pr_div - 4'h1;
	// prescale 1, 3, 4 or 13 shared by both directions
	always_ff @(posedge clk_i)
	begin
		if (rst_i | pr_tick)
			pr_cnt <= 4'h0;
		else
			pr_cnt <= pr_cnt + 4'h1;
	end

	wire [14:0] div_lim [2];
	// fine divider per direction, zero bypasses
	assign div_lim[0] = asc_pkg::asc_div(baud.tx_rate_sel, tx_fine_prescaler);
	assign div_lim[1] = asc_pkg::asc_div(baud.rx_rate_sel, rx_fine_prescaler);

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_div
			logic [14:0] cnt;
			wire         wrap = pr_tick & (cnt == div_lim[g] - 15'h0001);
			assign samp_tick[g] = wrap;
			always_ff @(posedge clk_i)
			begin
				if (rst_i | wrap)
					cnt <= 15'h0000;
				else if (pr_tick)
					cnt <= cnt + 15'h0001;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// config registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			baud              <= asc_pkg::BAUD_RESET;
			tx_fine_prescaler <= asc_pkg::FINE_RESET;
			rx_fine_prescaler <= asc_pkg::FINE_RESET;
			tx_ninth_bit      <= 1'b0;
			word9             <= 1'b0;
			wake_sel          <= 1'b0;
		end
		else if (wr)
		begin
			if (adr_i == asc_pkg::OFF_BAUD)
				baud <= dat_i[7:0];
			if (adr_i == asc_pkg::OFF_TX_FINE)
				tx_fine_prescaler <= dat_i[7:0];
			if (adr_i == asc_pkg::OFF_RX_FINE)
				rx_fine_prescaler <= dat_i[7:0];
			if (adr_i == asc_pkg::OFF_CTRL1)
			begin
				tx_ninth_bit <= dat_i[asc_pkg::C1_TX9];
				word9        <= dat_i[asc_pkg::C1_WORD9];
				wake_sel     <= dat_i[asc_pkg::C1_WAKE];
			end
		end
	end

	wire [3:0] frame_len = word9 ? asc_pkg::FRAME_9 : asc_pkg::FRAME_8;

	////////////////////////////////////////////////////////////////////////
	// transmitter
	asc_pkg::asc_tx_state_e tx_state;
	asc_pkg::asc_tx_kind_e  tx_kind;
	asc_pkg::asc_tx_state_e next_tx_state;
	asc_pkg::asc_tx_kind_e  next_kind;
	logic [10:0] tx_shift;
	logic [3:0]  tx_left;
	logic [3:0]  tx_phase;
	logic        te_d;
	logic        pre_pend;
	logic        next_load;
	logic        next_from_hold;
	logic        next_direct;

	wire te_rise   = c2.tx_enable & ~te_d;
	wire bit_tick  = samp_tick[0] & (tx_phase == asc_pkg::PH_LAST);
	wire frame_end = (tx_state == asc_pkg::TX_SHIFT) & bit_tick &
		(tx_left == asc_pkg::MARK_LEN);
	wire can_start = (tx_state == asc_pkg::TX_READY) | frame_end;

	// start 0, data lsb first, ninth bit, stop 1
	function automatic logic [10:0] tx_pattern(input logic [1:0] kind,
		input logic [7:0] d, input logic t8, input logic w9);
		case (kind)
			asc_pkg::KIND_DATA: return {1'b1, w9 ? t8 : 1'b1, d, 1'b0};
			asc_pkg::KIND_BRK:  return 11'h000;
			default:            return 11'h7ff;
		endcase
	endfunction

	always_comb
	begin
		next_tx_state  = tx_state;
		next_kind      = tx_kind;
		next_load      = 1'b0;
		next_from_hold = 1'b0;
		next_direct    = 1'b0;
		case (tx_state)
			asc_pkg::TX_OFF:
				if (c2.tx_enable)
					next_tx_state = asc_pkg::TX_READY;
			asc_pkg::TX_READY, asc_pkg::TX_SHIFT:
				if (can_start)
				begin
					next_load = 1'b1;
					// idle frame before data after enable
					if (pre_pend)
						next_kind = asc_pkg::KIND_PRE;
					else if (c2.break_send)
						next_kind = asc_pkg::KIND_BRK;
					// one mark bit after last break
					else if (frame_end & (tx_kind == asc_pkg::KIND_BRK))
						next_kind = asc_pkg::KIND_MARK;
					else if (hold_full)
					begin
						next_kind      = asc_pkg::KIND_DATA;
						next_from_hold = 1'b1;
					end
					// idle write goes straight to shifter
					else if (data_wr & (tx_state == asc_pkg::TX_READY))
					begin
						next_kind   = asc_pkg::KIND_DATA;
						next_direct = 1'b1;
					end
					else
						next_load = 1'b0;
					if (next_load & c2.tx_enable)
						next_tx_state = asc_pkg::TX_SHIFT;
					else if (next_load)
						next_tx_state = asc_pkg::TX_SHIFT;
					else if (c2.tx_enable)
						next_tx_state = asc_pkg::TX_READY;
					else
						next_tx_state = asc_pkg::TX_OFF;
				end
			default:
				next_tx_state = asc_pkg::TX_OFF;
		endcase
		// a disabled transmitter starts nothing new
		if (~c2.tx_enable & can_start)
		begin
			next_load      = 1'b0;
			next_from_hold = 1'b0;
			next_direct    = 1'b0;
			next_tx_state  = asc_pkg::TX_OFF;
		end
	end

	wire [7:0]  load_data = next_direct ? dat_i[7:0] : tx_holding_buffer;
	wire [3:0]  load_len  = (next_kind == asc_pkg::KIND_MARK) ?
		asc_pkg::MARK_LEN : frame_len;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_state <= asc_pkg::TX_OFF;
			tx_kind  <= asc_pkg::KIND_PRE;
			tx_shift <= 11'h7ff;
			tx_left  <= 4'h0;
			tx_phase <= asc_pkg::PH_FIRST;
			te_d     <= 1'b0;
			pre_pend <= 1'b0;
		end
		else
		begin
			tx_state <= next_tx_state;
			te_d     <= c2.tx_enable;
			if (next_load)
			begin
				tx_kind  <= next_kind;
				tx_shift <= tx_pattern(next_kind, load_data, tx_ninth_bit,
					word9);
				tx_left  <= load_len;
				tx_phase <= asc_pkg::PH_FIRST;
			end
			else
			begin
				if (samp_tick[0])
					tx_phase <= tx_phase + 4'h1;
				if (bit_tick & (tx_state == asc_pkg::TX_SHIFT))
				begin
					tx_shift <= {1'b1, tx_shift[10:1]};
					tx_left  <= tx_left - 4'h1;
				end
			end
			// re-enable queues a fresh idle frame
			if (te_rise)
				pre_pend <= 1'b1;
			else if (next_load & (next_kind == asc_pkg::KIND_PRE))
				pre_pend <= 1'b0;
		end
	end

	// busy write parks in the holding buffer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hold_full         <= 1'b0;
			tx_holding_buffer <= 8'h00;
		end
		else if (data_wr & ~next_direct)
		begin
			hold_full         <= 1'b1;
			tx_holding_buffer <= dat_i[7:0];
		end
		else if (next_from_hold | te_rise)
			hold_full <= 1'b0;
	end

	// low start, high stop, high when enabled and quiet
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tx_line_o    <= 1'b1;
			tx_line_oe_o <= 1'b0;
		end
		else
		begin
			tx_line_o    <= (tx_state == asc_pkg::TX_SHIFT) ? tx_shift[0]
				: 1'b1;
			tx_line_oe_o <= c2.tx_enable | c2.rx_enable |
				(tx_state == asc_pkg::TX_SHIFT);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receiver
	asc_pkg::asc_rx_state_e rx_state;
	logic [3:0] rx_phase;
	logic [3:0] rx_bits;
	logic [8:0] rx_shift;
	logic       smp1;
	logic       smp2;
	logic       rx_noise;
	logic [7:0] idle_cnt;
	logic       idle_armed;

	wire centre  = samp_tick[1] & (rx_phase == asc_pkg::PH_S3);
	wire bit_val = (smp1 & smp2) | (smp1 & rx_line_i) | (smp2 & rx_line_i);
	wire bit_bad = ~((smp1 == smp2) & (smp2 == rx_line_i));
	wire rx_done = centre & (rx_state == asc_pkg::RX_STOP);
	wire frm_err = ~bit_val;
	wire [7:0] idle_lim = {frame_len, 4'h0};
	wire idle_ev = samp_tick[1] & (rx_state == asc_pkg::RX_HUNT) &
		idle_armed & rx_line_i & (idle_cnt == idle_lim - 8'h01);
	wire [3:0] data_len = word9 ? asc_pkg::DATA_9 : asc_pkg::DATA_8;
	wire [7:0] rx_byte  = word9 ? rx_shift[7:0] : rx_shift[8:1];
	wire noisy_word = rx_noise | bit_bad;

	always_ff @(posedge clk_i)
	begin
		if (rst_i | ~c2.rx_enable)
		begin
			rx_state   <= asc_pkg::RX_OFF;
			rx_phase   <= asc_pkg::PH_FIRST;
			rx_bits    <= 4'h0;
			rx_shift   <= 9'h000;
			smp1       <= 1'b1;
			smp2       <= 1'b1;
			rx_noise   <= 1'b0;
			idle_cnt   <= 8'h00;
			idle_armed <= 1'b0;
		end
		else if (samp_tick[1])
		begin
			rx_phase <= rx_phase + 4'h1;
			if (rx_phase == asc_pkg::PH_S1)
				smp1 <= rx_line_i;
			if (rx_phase == asc_pkg::PH_S2)
				smp2 <= rx_line_i;
			case (rx_state)
				// enabled receiver hunts for a start bit
				asc_pkg::RX_OFF, asc_pkg::RX_HUNT:
				begin
					rx_state <= asc_pkg::RX_HUNT;
					rx_phase <= asc_pkg::PH_FIRST;
					idle_cnt <= rx_line_i ? idle_cnt + 8'h01 : 8'h00;
					if (idle_ev)
					begin
						idle_armed <= 1'b0;
						idle_cnt   <= 8'h00;
					end
					if (~rx_line_i)
					begin
						rx_state <= asc_pkg::RX_START;
						rx_phase <= asc_pkg::PH_FIRST + 4'h1;
						rx_noise <= 1'b0;
						rx_bits  <= 4'h0;
					end
				end
				asc_pkg::RX_START:
					if (centre & bit_val)
						rx_state <= asc_pkg::RX_HUNT;
					else if (centre)
					begin
						rx_noise   <= bit_bad;
						idle_armed <= 1'b1;
						rx_state   <= asc_pkg::RX_DATA;
					end
				asc_pkg::RX_DATA:
					if (centre)
					begin
						rx_shift <= {bit_val, rx_shift[8:1]};
						rx_noise <= noisy_word;
						rx_bits  <= rx_bits + 4'h1;
						if (rx_bits == data_len - 4'h1)
							rx_state <= asc_pkg::RX_STOP;
					end
				asc_pkg::RX_STOP:
					if (centre)
					begin
						rx_state <= asc_pkg::RX_HUNT;
						idle_cnt <= 8'h00;
					end
				default:
					rx_state <= asc_pkg::RX_HUNT;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flags, mute and interrupt
	// address mark wakes and delivers
	wire addr_wake = c2.rx_mute & wake_sel & rx_done & rx_shift[8];
	wire idle_wake = c2.rx_mute & ~wake_sel & idle_ev;
	wire deliver   = rx_done & (~c2.rx_mute | addr_wake);
	wire idle_set  = idle_ev & ~c2.rx_mute;
	wire load_ok   = deliver & (~st.rxf | rx_clr);
	// full buffer means overrun, buffer kept
	wire ovr_set   = deliver & st.rxf & ~rx_clr;
	wire txe_set   = next_from_hold | next_direct | te_rise;
	wire rx_irq_ok = c2.rx_irq_en & ~c2.rx_mute;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st                <= asc_pkg::STATUS_RESET;
			rx_holding_buffer <= 8'h00;
			rx_ninth_bit      <= 1'b0;
		end
		else
		begin
			// tx-empty set again, set beats clear
			st.txe   <= (st.txe & ~tx_clr) | txe_set;
			// data and break frames mark done
			st.txd   <= (st.txd & ~tx_clr) | (frame_end &
				(tx_kind == asc_pkg::KIND_DATA |
				tx_kind == asc_pkg::KIND_BRK));
			st.rxf   <= (st.rxf & ~rx_clr) | deliver;
			st.idle  <= (st.idle & ~rx_clr) | idle_set;
			st.ovr   <= (st.ovr & ~rx_clr) | ovr_set;
			st.noise <= (st.noise & ~rx_clr) | (load_ok & noisy_word);
			st.frm   <= (st.frm & ~rx_clr) | (load_ok & frm_err);
			st.rsv   <= 1'b0;
			if (load_ok)
			begin
				rx_holding_buffer <= rx_byte;
				// ninth bit stored in 9-bit mode
				rx_ninth_bit      <= word9 & rx_shift[8];
			end
		end
	end

	// software write to control_two wins over a same-edge wake-up
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			c2 <= asc_pkg::CTRL2_RESET;
		else if (ctrl2_wr)
			c2 <= dat_i[7:0];
		else if (addr_wake | idle_wake)
			c2.rx_mute <= 1'b0;
	end

	// empty, done, receive and idle requests under global mask
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= ~irq_mask_i & ((st.txe & c2.tx_empty_irq_en) |
				(st.txd & c2.tx_done_irq_en) |
				((st.rxf | st.ovr) & rx_irq_ok) |
				(st.idle & c2.idle_irq_en & ~c2.rx_mute));
	end

endmodule // asc_core

// ==== asc_core_sva.sv ====
`timescale 1ns/10ps
module asc_core_sva
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic [31:0] dat_o,
	input wire logic        irq_mask_i,
	input wire logic        irq_o,
	input wire logic        tx_line_o,
	input wire logic        tx_line_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////
	ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus request not answered next cycle");
	ack_once_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	rd_quiet_a: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");
	rd_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	irq_masked_a: assert property (irq_mask_i[*2] |-> !irq_o)
		else $error("interrupt while masked");
	line_idle_a: assert property (!tx_line_oe_o |-> tx_line_o)
		else $error("line low while released");
	// a low cell lasts at least sixteen clock cycles
	cell_low_a: assert property ($fell(tx_line_o) |->
		!tx_line_o[*8] ##1 !tx_line_o[*8])
		else $error("short low bit cell");
	cell_high_a: assert property ($rose(tx_line_o) && tx_line_oe_o |->
		tx_line_o[*8] ##1 tx_line_o[*8])
		else $error("short high bit cell");
endmodule // asc_core_sva

bind asc_core asc_core_sva chk_i (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
	.irq_mask_i(irq_mask_i), .irq_o(irq_o), .tx_line_o(tx_line_o),
	.tx_line_oe_o(tx_line_oe_o));

// ==== asc_core_test.sv ====
`timescale 1ns/10ps
module asc_core_test;
	localparam logic [4:0] ST = asc_pkg::OFF_STATUS;
	localparam logic [4:0] DT = asc_pkg::OFF_DATA;
	localparam logic [4:0] C1 = asc_pkg::OFF_CTRL1;
	localparam logic [4:0] C2 = asc_pkg::OFF_CTRL2;
	logic                       clk_i = 1'b0;
	logic                       rst_i = 1'b1;
	logic [asc_pkg::ADDR_W-1:0] adr_i = 5'h00;
	logic [31:0]                dat_i = 32'h0;
	logic [31:0]                dat_o;
	logic                       we_i = 1'b0;
	logic [3:0]                 sel_i = 4'h0;
	logic                       cyc_i = 1'b0;
	logic                       stb_i = 1'b0;
	logic                       ack_o;
	logic                       irq_mask_i = 1'b0;
	logic                       irq_o;
	logic                       rx_line;
	logic                       tx_line_o;
	logic                       tx_line_oe_o;
	logic                       tx_wire;
	logic                       hi;
	logic [8:0]                 q;
	int                         num_errors = 0;
	int                         n_tests = 0;
	always #20 clk_i = ~clk_i;
	// pull-up holds the wire high once the core lets go
	assign tx_wire = tx_line_oe_o ? tx_line_o : 1'b1;
	asc_core DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
		.dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
		.irq_mask_i(irq_mask_i), .irq_o(irq_o), .rx_line_i(rx_line),
		.tx_line_o(tx_line_o), .tx_line_oe_o(tx_line_oe_o));
	asc_far_end far (.clk_i(clk_i), .line_i(tx_wire), .line_o(rx_line));
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [8:0] got,
		input logic [8:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		adr_i <= a;
		we_i <= w;
		sel_i <= 4'hf;
		dat_i <= {24'h0, d};
		@(posedge clk_i);
		// only the watchdog ends a wait for ack
		while (ack_o !== 1'b1)
			@(posedge clk_i);
		q = {1'b0, dat_o[7:0]};
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wt_got(input int n);
		for (int i = 0; i < 3000 && far.got.size() < n; i++)
			@(posedge clk_i);
		repeat (20) @(posedge clk_i);
	endtask
	////////////////////////////////////////
	task automatic t_reset;
		wb(ST, 0, 0);
		chk("status", q, {1'b0, asc_pkg::STATUS_RESET});
		wb(C2, 0, 0);
		chk("ctrl2", q, 9'h000);
		wb(5'h1c, 1, 8'hff);
		wb(5'h1c, 0, 0);
		chk("unmapped", q, 9'h000);
	endtask
	task automatic t_tx;
		wb(asc_pkg::OFF_BAUD, 1, 0);
		wb(C2, 1, 8'h4c);
		wb(ST, 0, 0);
		wb(DT, 1, 8'ha5);
		hi = 1'b1;
		repeat (130)
		begin
			@(posedge clk_i);
			hi &= tx_wire;
		end
		chk("preamble", {8'h00, hi}, 9'h001);
		for (int i = 0; i < 100 && q[7] !== 1'b1; i++)
			wb(ST, 0, 0);
		chk("no done", q & 9'h0c0, 9'h080);
		wb(DT, 1, 8'h3c);
		wb(ST, 0, 0);
		chk("held", q & 9'h080, 9'h000);
		wt_got(2);
		chk("tx0", far.got[0], 9'h0a5);
		chk("tx1", far.got[1], 9'h03c);
		wb(ST, 0, 0);
		chk("done", q & 9'h040, 9'h040);
		chk("done irq", {8'h00, irq_o}, 9'h001);
		irq_mask_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("masked", {8'h00, irq_o}, 9'h000);
		irq_mask_i <= 1'b0;
		wb(DT, 1, 8'h0f);
		wb(ST, 0, 0);
		chk("direct", q & 9'h0c0, 9'h080);
		wt_got(3);
		chk("tx2", far.got[2], 9'h00f);
		wb(C2, 1, 8'h8c);
		// irq is registered, let the new enable reach it
		repeat (2) @(posedge clk_i);
		chk("empty irq", {8'h00, irq_o}, 9'h001);
	endtask
	task automatic t_rx;
		wb(C2, 1, 8'h2c);
		far.send(9'h05a, 1'b1);
		repeat (4) @(posedge clk_i);
		wb(ST, 0, 0);
		chk("rx full", q & 9'h02e, 9'h020);
		chk("rx irq", {8'h00, irq_o}, 9'h001);
		wb(DT, 0, 0);
		chk("rx data", q, 9'h05a);
		wb(ST, 0, 0);
		chk("rx clear", q & 9'h020, 9'h000);
		far.send(9'h011, 1'b1);
		far.send(9'h022, 1'b1);
		repeat (4) @(posedge clk_i);
		wb(ST, 0, 0);
		chk("overrun", q & 9'h02e, 9'h028);
		wb(DT, 0, 0);
		chk("kept", q, 9'h011);
		far.send(9'h033, 1'b0);
		repeat (4) @(posedge clk_i);
		wb(ST, 0, 0);
		chk("framing", q & 9'h02e, 9'h022);
		wb(DT, 0, 0);
		chk("frm data", q, 9'h033);
		repeat (200) @(posedge clk_i);
		wb(ST, 0, 0);
		chk("idle", q & 9'h010, 9'h010);
		wb(DT, 0, 0);
	endtask
	task automatic t_mute;
		far.nb = 9;
		wb(C1, 1, 8'h58);
		// control_two only set here, read back after the wake-up
		wb(C2, 1, 8'h2e);
		far.send(9'h044, 1'b1);
		repeat (4) @(posedge clk_i);
		wb(ST, 0, 0);
		chk("muted", q & 9'h020, 9'h000);
		chk("muted irq", {8'h00, irq_o}, 9'h000);
		far.send(9'h155, 1'b1);
		repeat (4) @(posedge clk_i);
		wb(ST, 0, 0);
		chk("woken", q & 9'h020, 9'h020);
		wb(C2, 0, 0);
		chk("unmuted", q & 9'h002, 9'h000);
		wb(C1, 0, 0);
		chk("ninth rx", q & 9'h080, 9'h080);
		wb(DT, 0, 0);
		chk("address", q, 9'h055);
		wb(ST, 0, 0);
		wb(DT, 1, 8'h81);
		wt_got(4);
		chk("ninth tx", far.got[3], 9'h181);
	endtask
	task automatic t_wake;
		wb(ST, 0, 0);
		wb(DT, 0, 0);
		wb(C1, 1, 8'h50);
		wb(C2, 1, 8'h2e);
		far.send(9'h1aa, 1'b1);
		repeat (200) @(posedge clk_i);
		wb(ST, 0, 0);
		chk("idle wake", q & 9'h030, 9'h000);
		wb(C2, 0, 0);
		chk("idle unmute", q & 9'h002, 9'h000);
	endtask
	task automatic t_brk;
		wb(C2, 1, 8'h0d);
		repeat (40) @(posedge clk_i);
		chk("break", {8'h00, tx_wire}, 9'h000);
		wb(C2, 1, 8'h0c);
		repeat (200) @(posedge clk_i);
		chk("mark", {8'h00, tx_wire}, 9'h001);
	endtask
	////////////////////////////////////////
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		t_tx;
		t_rx;
		t_mute;
		t_wake;
		t_brk;
		close_out;
	end
	// whole run needs a few thousand cycles
	initial
	begin
		repeat (30000) @(posedge clk_i);
		num_errors++;
		close_out;
	end
endmodule // asc_core_test

// ==== asc_far_end.sv ====
`timescale 1ns/10ps
module asc_far_end
(
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      line_o
);
	logic [8:0] got[$];
	int         nb = 8;
	logic [8:0] v;
	initial line_o = 1'b1;
	task automatic send(input logic [8:0] d, input logic stp);
		line_o <= 1'b0;
		repeat (16) @(posedge clk_i);
		for (int i = 0; i < nb; i++)
		begin
			line_o <= d[i];
			repeat (16) @(posedge clk_i);
		end
		line_o <= stp;
		repeat (16) @(posedge clk_i);
		line_o <= 1'b1;
		// one idle cycle so back-to-back frames never reassign in one step
		@(posedge clk_i);
	endtask
	////////////////////////////////////////
	// sample at cell centres
	initial forever
	begin
		@(posedge clk_i);
		if (line_i === 1'b0)
		begin
			v = 9'h000;
			repeat (8) @(posedge clk_i);
			for (int i = 0; i < nb; i++)
			begin
				repeat (16) @(posedge clk_i);
				v[i] = line_i;
			end
			repeat (16) @(posedge clk_i);
			got.push_back(v);
		end
	end
endmodule // asc_far_end

// ==== asc_pkg.sv ====
package asc_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map, byte addresses on the 32-bit bus
	localparam int unsigned ADDR_W = 5;
	localparam logic [4:0] OFF_STATUS  = 5'h00;
	localparam logic [4:0] OFF_DATA    = 5'h04;
	localparam logic [4:0] OFF_CTRL1   = 5'h08;
	localparam logic [4:0] OFF_CTRL2   = 5'h0c;
	localparam logic [4:0] OFF_BAUD    = 5'h10;
	localparam logic [4:0] OFF_TX_FINE = 5'h14;
	localparam logic [4:0] OFF_RX_FINE = 5'h18;

	localparam logic [7:0] STATUS_RESET = 8'hc0;
	localparam logic [7:0] CTRL2_RESET  = 8'h00;
	localparam logic [7:0] BAUD_RESET   = 8'h00;
	localparam logic [7:0] FINE_RESET   = 8'h00;

	// control_one bit positions
	localparam int unsigned C1_RX9   = 7;
	localparam int unsigned C1_TX9   = 6;
	localparam int unsigned C1_WORD9 = 4;
	localparam int unsigned C1_WAKE  = 3;

	////////////////////////////////////////////////////////////////////////
	// oversampling and frame timing
	localparam logic [3:0] PH_FIRST = 4'h0;
	localparam logic [3:0] PH_S1    = 4'h7;
	localparam logic [3:0] PH_S2    = 4'h8;
	localparam logic [3:0] PH_S3    = 4'h9;
	localparam logic [3:0] PH_LAST  = 4'hf;
	localparam logic [3:0] FRAME_8  = 4'ha;
	localparam logic [3:0] FRAME_9  = 4'hb;
	localparam logic [3:0] DATA_8   = 4'h8;
	localparam logic [3:0] DATA_9   = 4'h9;
	localparam logic [3:0] MARK_LEN = 4'h1;
	localparam logic [3:0] PR_SEL0  = 4'h1;
	localparam logic [3:0] PR_SEL1  = 4'h3;
	localparam logic [3:0] PR_SEL2  = 4'h4;
	localparam logic [3:0] PR_SEL3  = 4'hd;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic txe;
		logic txd;
		logic rxf;
		logic idle;
		logic ovr;
		logic noise;
		logic frm;
		logic rsv;
	} asc_status_s;

	typedef struct packed {
		logic tx_empty_irq_en;
		logic tx_done_irq_en;
		logic rx_irq_en;
		logic idle_irq_en;
		logic tx_enable;
		logic rx_enable;
		logic rx_mute;
		logic break_send;
	} asc_ctrl2_s;

	typedef struct packed {
		logic [1:0] common_prescale_sel;
		logic [2:0] tx_rate_sel;
		logic [2:0] rx_rate_sel;
	} asc_baud_s;

	typedef enum logic [1:0] {
		TX_OFF   = 2'b00,
		TX_READY = 2'b01,
		TX_SHIFT = 2'b10
	} asc_tx_state_e;

	typedef enum logic [1:0] {
		KIND_DATA = 2'b00,
		KIND_PRE  = 2'b01,
		KIND_BRK  = 2'b10,
		KIND_MARK = 2'b11
	} asc_tx_kind_e;

	typedef enum logic [2:0] {
		RX_OFF   = 3'b000,
		RX_HUNT  = 3'b001,
		RX_START = 3'b010,
		RX_DATA  = 3'b011,
		RX_STOP  = 3'b100
	} asc_rx_state_e;

	function automatic logic [3:0] asc_prescale(input logic [1:0] sel);
		case (sel)
			2'b00:   return PR_SEL0;
			2'b01:   return PR_SEL1;
			2'b10:   return PR_SEL2;
			default: return PR_SEL3;
		endcase
	endfunction

	// power-of-two rate times fine divider, zero fine means bypass
	function automatic logic [14:0] asc_div(input logic [2:0] rate,
		input logic [7:0] fine);
		logic [22:0] prod;
		logic [7:0]  f;
		f = (fine == 8'h00) ? 8'h01 : fine;
		prod = {8'h00, 15'h0001 << rate} * {15'h0000, f};
		return prod[14:0];
	endfunction

endpackage
